// File: core/dkp_defs.svh
/*
 * Constants of the derived-key engine: command word layout, routing codes,
 * derived key sizes and the descriptor rewrite command.
 * Assumes inclusion by bare name from the package and from the engine, controller and mix design files.
 */
`ifndef DKP_DEFS_SVH
`define DKP_DEFS_SVH

`define DKP_LEN_LSB 0
`define DKP_SRC_LSB 16
`define DKP_DST_LSB 18
`define DKP_ALG_LSB 20
`define DKP_MODE_BIT 24
`define DKP_KE_BIT 16
`define DKP_EKT_BIT 17
`define DKP_SD_LSB 18

`define RT_INLINE 2'h0
`define RT_SEQ 2'h1
`define RT_PTR 2'h2
`define RT_SG 2'h3

`define SD_PTR 2'h0
`define SD_SG 2'h1
`define SD_SEQ 2'h2

`define ALG_MD5 4'h0
`define ALG_SHA1 4'h1
`define ALG_SHA224 4'h2
`define ALG_SHA256 4'h3
`define ALG_SHA384 4'h4
`define ALG_SHA512 4'h5

`define HALF_MD5 5'h04
`define HALF_SHA1 5'h06
`define USED_SHA1 5'h05
`define HALF_SHA256 5'h08
`define HALF_SHA512 5'h10
`define BLK_SMALL 6'h10
`define BLK_LARGE 6'h20

`define PAD_INNER 32'h36363636
`define PAD_OUTER 32'h5C5C5C5C
`define MIX_K 32'h9E3779B9
`define KEYLOAD_CMD 32'h04000000
`define SBOX_WORDS 7'h40

`endif

// File: core/dkp_device.sv
/*
 * Derived-key engine: keyed-hash key derivation and stream-cipher S-box
 * generation, with descriptor rewrite and key register load in hash mode.
 * Assumes the controller resolves each routing code into actual memory traffic.
 */
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "dkp_defs.svh"
module dkp_device import dkp_pkg::*; #(
	parameter int KEY_WORDS = 64
) (
	input wire logic clk,
	input wire logic rst,
	dkp_if.dev bus,
	output logic busy,
	output logic lastErr
);
	localparam logic [12:0] KEY_BYTES = 13'(KEY_WORDS * 4);

	dkp_state_t state_r;
	word_t cmd_r;
	word_t keyBuf [KEY_WORDS];
	word_t dk [32];
	logic [7:0] sbox [256];
	logic [6:0] wIdx_r;
	logic pass_r;
	logic [4:0] oIdx_r;
	logic [5:0] bIdx_r;
	word_t acc_r;
	logic [7:0] sI_r;
	logic [7:0] sJ_r;
	logic [7:0] kByte_r;
	logic [6:0] emitIdx_r;
	logic outValid_r;
	word_t outData_r;
	route_t outDest_r;
	logic outIsCmd_r;
	logic outLast_r;
	logic keyWrEn_r;
	logic [4:0] keyWrIdx_r;
	word_t keyWrData_r;
	logic done_r;
	logic err_r;
	logic lastErr_r;

	logic streamMode;
	route_t srcSel, dstSel, sdRoute, inRoute, outRoute;
	logic [3:0] alg;
	logic [11:0] keyLen;
	logic [12:0] nWords;
	logic [4:0] halfW, usedW;
	logic [5:0] blkW;
	logic [6:0] outTotal;
	logic cmdOk;
	word_t blkWord, mixOut, maskedWord, emitWord;
	logic [7:0] keyByte, jNext;
	logic [4:0] dkIdx;

	assign streamMode = cmd_r[`DKP_MODE_BIT];
	assign srcSel = cmd_r[`DKP_SRC_LSB +: 2];
	assign dstSel = cmd_r[`DKP_DST_LSB +: 2];
	assign alg = cmd_r[`DKP_ALG_LSB +: 4];
	assign keyLen = cmd_r[`DKP_LEN_LSB +: 12];
	assign nWords = ({1'b0, keyLen} + 13'h0003) >> 2;
	assign halfW = half_words(alg);
	assign usedW = used_words(alg);
	assign blkW = block_words(alg);

	// Stream mode reuses bits 18-19 as one shared routing code, never inline
	always_comb begin
		case (cmd_r[`DKP_SD_LSB +: 2])
			`SD_PTR: sdRoute = `RT_PTR;
			`SD_SG: sdRoute = `RT_SG;
			default: sdRoute = `RT_SEQ;
		endcase
	end

	assign inRoute = streamMode ? sdRoute : srcSel;
	assign outRoute = streamMode ? sdRoute : dstSel;
	assign outTotal = streamMode ? `SBOX_WORDS : {1'b0, halfW, 1'b0};

	// Hash keys longer than one block would need pre-hashing; those are refused
	always_comb begin
		if (streamMode) begin
			cmdOk = (cmd_r[`DKP_SD_LSB +: 2] != 2'h3) && (keyLen != 12'h000)
				&& ({1'b0, keyLen} <= KEY_BYTES);
		end else begin
			cmdOk = (halfW != 5'h00) && route_ok(srcSel, dstSel)
				&& ({1'b0, keyLen} <= {5'h00, blkW, 2'b00});
		end
	end

	// Bytes past the stated length count as zero
	for (genvar k = 0; k < 4; k++) begin : g_mask
		assign maskedWord[31 - 8 * k -: 8] =
			(({1'b0, bIdx_r, 2'b00} + 9'(k)) < keyLen[8:0] || keyLen > 12'h0FF)
			? keyBuf[bIdx_r][31 - 8 * k -: 8] : 8'h00;
	end

	assign blkWord = maskedWord ^ (pass_r ? `PAD_OUTER : `PAD_INNER);
	assign dkIdx = (pass_r ? halfW : 5'h00) + oIdx_r;

	hash_engine_mix #(.ROT(5)) u_mix (
		.acc(acc_r),
		.data(blkWord),
		.result(mixOut)
	);

	assign keyByte = keyBuf[kByte_r[7:2]][8 * (3 - kByte_r[1:0]) +: 8];
	assign jNext = sJ_r + sbox[sI_r] + keyByte;

	always_comb begin
		if (emitIdx_r == 7'h00) begin
			emitWord = `KEYLOAD_CMD | {18'h00000, outTotal, 2'b00, 5'h00};
		end else if (streamMode) begin
			emitWord = {sbox[{emitIdx_r[5:0] - 6'h01, 2'b00}], sbox[{emitIdx_r[5:0] - 6'h01, 2'b01}],
				sbox[{emitIdx_r[5:0] - 6'h01, 2'b10}], sbox[{emitIdx_r[5:0] - 6'h01, 2'b11}]};
		end else begin
			emitWord = dk[emitIdx_r[4:0] - 5'h01];
		end
	end

	// Sequencing of the whole operation
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			cmd_r <= 32'h00000000;
			wIdx_r <= 7'h00;
			pass_r <= 1'b0;
			oIdx_r <= 5'h00;
			bIdx_r <= 6'h00;
			acc_r <= 32'h00000000;
			sI_r <= 8'h00;
			sJ_r <= 8'h00;
			kByte_r <= 8'h00;
			emitIdx_r <= 7'h00;
			done_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			err_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (bus.cmdValid) begin
						cmd_r <= bus.cmdWord;
						state_r <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					wIdx_r <= 7'h00;
					pass_r <= 1'b0;
					oIdx_r <= 5'h00;
					bIdx_r <= 6'h00;
					sI_r <= 8'h00;
					sJ_r <= 8'h00;
					kByte_r <= 8'h00;
					acc_r <= `PAD_INNER;
					emitIdx_r <= streamMode ? 7'h01 : 7'h00;
					if (!cmdOk) begin
						err_r <= 1'b1;
						state_r <= ST_IDLE;
					end else if (nWords == 13'h0000) begin
						state_r <= ST_HASH;
					end else begin
						state_r <= ST_RECV;
					end
				end
				ST_RECV: begin
					if (bus.inValid) begin
						wIdx_r <= wIdx_r + 7'h01;
						if ({6'h00, wIdx_r} == nWords - 13'h0001) begin
							state_r <= streamMode ? ST_SB_INIT : ST_HASH;
						end
					end
				end
				ST_HASH: begin
					// Two passes, inner then outer, each a full block per output word
					if (bIdx_r == blkW - 6'h01) begin
						bIdx_r <= 6'h00;
						if (oIdx_r == halfW - 5'h01) begin
							oIdx_r <= 5'h00;
							acc_r <= `PAD_OUTER;
							pass_r <= 1'b1;
							if (pass_r) begin
								state_r <= ST_EMIT;
							end
						end else begin
							oIdx_r <= oIdx_r + 5'h01;
							acc_r <= (pass_r ? `PAD_OUTER : `PAD_INNER) ^ {27'h0000000, oIdx_r + 5'h01};
						end
					end else begin
						acc_r <= mixOut;
						bIdx_r <= bIdx_r + 6'h01;
					end
				end
				ST_SB_INIT: begin
					sI_r <= sI_r + 8'h01;
					if (sI_r == 8'hFF) begin
						state_r <= ST_SB_MIX;
					end
				end
				ST_SB_MIX: begin
					sJ_r <= jNext;
					sI_r <= sI_r + 8'h01;
					kByte_r <= ({4'h0, kByte_r} + 12'h001 == keyLen) ? 8'h00 : kByte_r + 8'h01;
					if (sI_r == 8'hFF) begin
						state_r <= ST_EMIT;
					end
				end
				ST_EMIT: begin
					if (!outValid_r || bus.outReady) begin
						if (emitIdx_r <= outTotal) begin
							emitIdx_r <= emitIdx_r + 7'h01;
						end else begin
							state_r <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					done_r <= 1'b1;
					state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Storage arrays; contents are only meaningful within one operation
	always_ff @(posedge clk) begin
		if (state_r == ST_RECV && bus.inValid) begin
			keyBuf[wIdx_r[5:0]] <= bus.inData;
		end
		if (state_r == ST_HASH && bIdx_r == blkW - 6'h01) begin
			dk[dkIdx] <= (oIdx_r >= usedW) ? 32'h00000000 : mixOut;
		end
		if (state_r == ST_SB_INIT) begin
			sbox[sI_r] <= sI_r;
		end
		if (state_r == ST_SB_MIX) begin
			sbox[sI_r] <= sbox[jNext];
			sbox[jNext] <= sbox[sI_r];
		end
	end

	// Output word stream; in hash mode the command word leads so inline key lands after it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			outValid_r <= 1'b0;
			outData_r <= 32'h00000000;
			outDest_r <= `RT_INLINE;
			outIsCmd_r <= 1'b0;
			outLast_r <= 1'b0;
		end else if (state_r == ST_EMIT && (!outValid_r || bus.outReady)) begin
			outValid_r <= (emitIdx_r <= outTotal);
			outData_r <= emitWord;
			outIsCmd_r <= (emitIdx_r == 7'h00);
			outDest_r <= (emitIdx_r == 7'h00) ? `RT_INLINE : outRoute;
			outLast_r <= (emitIdx_r == outTotal);
		end
	end

	// Each derived word goes into the key register as it is produced
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			keyWrEn_r <= 1'b0;
			keyWrIdx_r <= 5'h00;
			keyWrData_r <= 32'h00000000;
		end else begin
			keyWrEn_r <= (state_r == ST_HASH && bIdx_r == blkW - 6'h01);
			keyWrIdx_r <= dkIdx;
			keyWrData_r <= (oIdx_r >= usedW) ? 32'h00000000 : mixOut;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lastErr_r <= 1'b0;
		end else if (err_r || done_r) begin
			lastErr_r <= err_r;
		end
	end

	assign bus.cmdReady = (state_r == ST_IDLE);
	assign bus.inReady = (state_r == ST_RECV);
	assign bus.inSrc = inRoute;
	assign bus.outValid = outValid_r;
	assign bus.outData = outData_r;
	assign bus.outDest = outDest_r;
	assign bus.outIsCmd = outIsCmd_r;
	assign bus.outLast = outLast_r;
	assign bus.keyWrEn = keyWrEn_r;
	assign bus.keyWrIdx = keyWrIdx_r;
	assign bus.keyWrData = keyWrData_r;
	assign bus.encFlag = streamMode & cmd_r[`DKP_KE_BIT];
	assign bus.encFormat = streamMode & cmd_r[`DKP_EKT_BIT];
	assign bus.done = done_r;
	assign bus.err = err_r;
	assign busy = (state_r != ST_IDLE);
	assign lastErr = lastErr_r;
endmodule : dkp_device

// File: core/dkp_host.sv
/*
 * Descriptor controller end: screens and issues derivation commands, feeds the
 * negotiated key, forwards results and holds the second-class key register.
 * Assumes the user side supplies key words already fetched per routing code.
 */
`timescale 1ns/1ps
`include "dkp_defs.svh"
module dkp_host import dkp_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	dkp_if.host bus,
	input wire logic opValid,
	input wire logic [31:0] opWord,
	input wire logic trusted,
	input wire logic [5:0] spareWords,
	output logic opReady,
	output logic opRejected,
	input wire logic keyValid,
	input wire logic [31:0] keyData,
	output logic keyReady,
	output logic resValid,
	output logic [31:0] resData,
	output logic [1:0] resDest,
	output logic resIsCmd,
	output logic resLast,
	input wire logic resReady,
	output logic opDone,
	output logic opErr,
	input wire logic [4:0] keyRdIdx,
	output logic [31:0] keyRdData
);
	logic busy_r;
	logic cmdValid_r;
	word_t cmdWord_r;
	logic rejected_r;
	logic done_r;
	logic err_r;
	word_t keyReg [32];
	word_t keyRd_r;
	logic legal;
	route_t src, dst, sd;
	logic [5:0] needWords;

	assign src = opWord[`DKP_SRC_LSB +: 2];
	assign dst = opWord[`DKP_DST_LSB +: 2];
	assign sd = opWord[`DKP_SD_LSB +: 2];
	assign needWords = {half_words(opWord[`DKP_ALG_LSB +: 4]), 1'b0} + 6'h01;

	always_comb begin
		if (opWord[`DKP_MODE_BIT]) begin
			legal = !trusted || (sd == `SD_SEQ);
		end else begin
			legal = route_ok(src, dst);
			if (trusted && (src != `RT_SEQ || dst != `RT_SEQ)) begin
				legal = 1'b0;
			end
			if (dst == `RT_INLINE && needWords > spareWords) begin
				legal = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_r <= 1'b0;
			cmdValid_r <= 1'b0;
			cmdWord_r <= 32'h00000000;
			rejected_r <= 1'b0;
		end else begin
			rejected_r <= 1'b0;
			if (!busy_r && opValid) begin
				busy_r <= legal;
				cmdValid_r <= legal;
				cmdWord_r <= opWord;
				rejected_r <= !legal;
			end else begin
				if (cmdValid_r && bus.cmdReady) begin
					cmdValid_r <= 1'b0;
				end
				if (bus.done || bus.err) begin
					busy_r <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done_r <= 1'b0;
			err_r <= 1'b0;
			keyRd_r <= 32'h00000000;
		end else begin
			done_r <= bus.done;
			err_r <= bus.err;
			keyRd_r <= keyReg[keyRdIdx];
		end
	end

	// Key register holds whatever the last derivation left in it
	always_ff @(posedge clk) begin
		if (bus.keyWrEn) begin
			keyReg[bus.keyWrIdx] <= bus.keyWrData;
		end
	end

	assign bus.cmdValid = cmdValid_r;
	assign bus.cmdWord = cmdWord_r;
	assign bus.inValid = keyValid & busy_r;
	assign bus.inData = keyData;
	assign keyReady = bus.inReady & busy_r;
	assign bus.outReady = resReady;
	assign resValid = bus.outValid;
	assign resData = bus.outData;
	assign resDest = bus.outDest;
	assign resIsCmd = bus.outIsCmd;
	assign resLast = bus.outLast;
	assign opReady = !busy_r;
	assign opRejected = rejected_r;
	assign opDone = done_r;
	assign opErr = err_r;
	assign keyRdData = keyRd_r;
endmodule : dkp_host

// File: core/dkp_if.sv
/*
 * Link between the descriptor controller and the derived-key engine.
 * Assumes both ends share clk; the testbench instantiates and joins them.
 */
`timescale 1ns/1ps
interface dkp_if;
	import dkp_pkg::*;
	logic cmdValid;
	logic cmdReady;
	word_t cmdWord;
	logic inValid;
	logic inReady;
	word_t inData;
	route_t inSrc;
	logic outValid;
	logic outReady;
	word_t outData;
	route_t outDest;
	logic outIsCmd;
	logic outLast;
	logic keyWrEn;
	logic [4:0] keyWrIdx;
	word_t keyWrData;
	logic encFlag;
	logic encFormat;
	logic done;
	logic err;

	modport dev(input cmdValid, cmdWord, inValid, inData, outReady,
		output cmdReady, inReady, inSrc, outValid, outData, outDest, outIsCmd, outLast,
		keyWrEn, keyWrIdx, keyWrData, encFlag, encFormat, done, err);
	modport host(output cmdValid, cmdWord, inValid, inData, outReady,
		input cmdReady, inReady, inSrc, outValid, outData, outDest, outIsCmd, outLast,
		keyWrEn, keyWrIdx, keyWrData, encFlag, encFormat, done, err);
endinterface : dkp_if

// File: core/dkp_pkg.sv
/*
 * Types and size functions shared by both ends of the derived-key link.
 * Assumes dkp_defs.svh is on the include path.
 */
`include "dkp_defs.svh"
package dkp_pkg;
	typedef logic [31:0] word_t;
	typedef logic [1:0] route_t;
	typedef enum {ST_IDLE, ST_CHECK, ST_RECV, ST_HASH, ST_SB_INIT, ST_SB_MIX, ST_EMIT, ST_DONE} dkp_state_t;

	// Stored words per half; zero marks an unsupported algorithm
	function automatic logic [4:0] half_words(input logic [3:0] alg);
		case (alg)
			`ALG_MD5: half_words = `HALF_MD5;
			`ALG_SHA1: half_words = `HALF_SHA1;
			`ALG_SHA224, `ALG_SHA256: half_words = `HALF_SHA256;
			`ALG_SHA384, `ALG_SHA512: half_words = `HALF_SHA512;
			default: half_words = 5'h00;
		endcase
	endfunction : half_words

	function automatic logic [4:0] used_words(input logic [3:0] alg);
		used_words = (alg == `ALG_SHA1) ? `USED_SHA1 : half_words(alg);
	endfunction : used_words

	function automatic logic [5:0] block_words(input logic [3:0] alg);
		block_words = (alg == `ALG_SHA384 || alg == `ALG_SHA512) ? `BLK_LARGE : `BLK_SMALL;
	endfunction : block_words

	// Source/destination pairs the engine accepts in hash mode
	function automatic logic route_ok(input route_t src, input route_t dst);
		case (dst)
			`RT_INLINE: route_ok = 1'b1;
			`RT_SEQ: route_ok = (src == `RT_SEQ);
			`RT_PTR: route_ok = (src == `RT_SEQ) || (src == `RT_PTR);
			`RT_SG: route_ok = (src == `RT_SEQ) || (src == `RT_SG);
			default: route_ok = 1'b0;
		endcase
		if (src == `RT_INLINE && dst != `RT_INLINE) begin
			route_ok = 1'b0;
		end
	endfunction : route_ok
endpackage : dkp_pkg

// File: core/hash_engine_mix.sv
/*
 * One step of the hash engine's block computation: folds a word into the
 * running state. Purely combinational; the caller sequences the steps.
 */
`timescale 1ns/1ps
`include "dkp_defs.svh"
module hash_engine_mix #(
	parameter int ROT = 5
) (
	input wire logic [31:0] acc,
	input wire logic [31:0] data,
	output logic [31:0] result
);
	logic [31:0] rotated;

	assign rotated = (acc << ROT) | (acc >> (32 - ROT));
	assign result = (rotated ^ data) + (acc ^ `MIX_K);
endmodule : hash_engine_mix

// File: tb/derived_key_protocol_tb.sv
/* Self-checking bench: controller and engine joined by the link, driven from the controller's user side.
 * Assumes the design files compile first; one 100 MHz clock. */
`timescale 1ns/1ps
module derived_key_protocol_tb import dkp_pkg::*; ();
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic opValid = 1'b0;
	logic trusted = 1'b0;
	logic keyValid = 1'b1;
	logic resReady = 1'b1;
	logic stall = 1'b0;
	logic [31:0] opWord = 32'h0;
	logic [31:0] keyData = 32'h00010203;
	logic [5:0] spareWords = 6'h3F;
	logic [4:0] keyRdIdx = 5'h00;
	logic opReady, opRejected, keyReady, resValid, resIsCmd, resLast, opDone, opErr;
	logic [31:0] resData, keyRdData;
	logic [1:0] resDest;
	logic rejSeen, doneSeen, errSeen, encSeen, fmtSeen;
	logic busy, lastErr;
	logic [1:0] srcSeen;
	logic [31:0] res [0:63];
	logic [1:0] rdst [0:63];
	int nWords, nKey, nWr, nCmd, lastAt, cycles = 0, mismatches = 0, num_checks = 0;

	dkp_if link();
	dkp_device i_dkp_device(.clk(clk), .rst(rst), .bus(link), .busy(busy), .lastErr(lastErr));
	dkp_host i_dkp_host(.clk(clk), .rst(rst), .bus(link), .opValid(opValid), .opWord(opWord), .trusted(trusted),
		.spareWords(spareWords), .opReady(opReady), .opRejected(opRejected), .keyValid(keyValid),
		.keyData(keyData), .keyReady(keyReady), .resValid(resValid), .resData(resData), .resDest(resDest),
		.resIsCmd(resIsCmd), .resLast(resLast), .resReady(resReady), .opDone(opDone), .opErr(opErr),
		.keyRdIdx(keyRdIdx), .keyRdData(keyRdData));
	key_link_checker i_key_link_checker(.clk(clk), .rst(rst), .cmdValid(link.cmdValid), .cmdReady(link.cmdReady),
		.cmdWord(link.cmdWord), .inReady(link.inReady), .outValid(link.outValid), .outReady(link.outReady),
		.outData(link.outData), .outDest(link.outDest), .outIsCmd(link.outIsCmd), .outLast(link.outLast),
		.keyWrEn(link.keyWrEn), .done(link.done), .err(link.err));

	always #5 clk = ~clk;

	// One process owns every per-operation tally, so clearing and counting never race
	always @(posedge clk) begin
		cycles <= cycles + 1;
		resReady <= !stall || !resReady;
		keyValid <= !stall || !keyValid;
		if (opValid && opReady) begin
			{rejSeen, doneSeen, errSeen} <= 3'b000;
			nWords <= 0;
			nKey <= 0;
			nWr <= 0;
			nCmd <= 0;
			lastAt <= -1;
		end else begin
			if (opRejected || opErr) rejSeen <= 1'b1;
			if (opErr) errSeen <= 1'b1;
			if (opDone) doneSeen <= 1'b1;
			if (keyValid && keyReady) begin
				keyData <= keyData + 32'h04040404;
				nKey <= nKey + 1;
				srcSeen <= link.inSrc;
			end
			if (link.keyWrEn) nWr <= nWr + 1;
			if (resValid && resReady) begin
				res[nWords[5:0]] <= resData;
				rdst[nWords[5:0]] <= resDest;
				nWords <= nWords + 1;
				if (resLast) lastAt <= nWords;
				nCmd <= nCmd + int'(resIsCmd);
				encSeen <= link.encFlag;
				fmtSeen <= link.encFormat;
			end
		end
	end

	always @(posedge clk) begin
		if (cycles == 80000) begin
			mismatches++;
			print_verdict;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict;
		if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict

	function automatic logic routeLegal(input logic [1:0] s, input logic [1:0] d);
		if (d == 2'h0) return 1'b1;
		if (s == 2'h0) return 1'b0;
		return (d == 2'h1) ? (s == 2'h1) : (d == 2'h2) ? (s != 2'h3) : (s != 2'h2);
	endfunction : routeLegal

	// Issues one operation and waits for its verdict; a refused one must emit nothing
	task automatic runOp(input logic [31:0] w, input logic tr, input logic ok);
		int n;
		@(posedge clk);
		opWord <= w;
		trusted <= tr;
		opValid <= 1'b1;
		@(posedge clk);
		opValid <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (!(opReady === 1'b1 && (rejSeen | doneSeen) === 1'b1) && n < 3000);
		check(n < 3000, 1'b1);
		check(rejSeen, !ok);
		check(doneSeen, ok);
		if (!ok) check(nWords, 0);
		if (ok || errSeen) check(lastErr, errSeen);
		check(busy, 1'b0);
	endtask : runOp

	task automatic hashCase(input logic [3:0] alg, input logic [1:0] src, input logic [1:0] dst,
		input logic tr, input logic ok, input logic [11:0] len);
		int h;
		h = (alg == 4'h0) ? 4 : (alg == 4'h1) ? 6 : (alg < 4'h4) ? 8 : 16;
		runOp({8'h00, alg, dst, src, 4'h0, len}, tr, ok);
		if (ok) begin
			check(nKey, (len + 3) / 4);
			check(nWords, 2 * h + 1);
			check(nCmd, 1);
			check(res[0], 32'h04000000 | (8 * h) << 5);
			check(rdst[0], 2'h0);
			check(rdst[2 * h], dst);
			check(nWr, 2 * h);
			check(lastAt, 2 * h);
			check(srcSeen, src);
			if (alg == 4'h1) begin
				check(res[6], 32'h0);
				check(res[12], 32'h0);
			end
			@(posedge clk);
			keyRdIdx <= 5'(2 * h - 1);
			repeat (2) @(posedge clk);
			#1;
			check(keyRdData, res[2 * h]);
		end
	endtask : hashCase

	task automatic streamCase(input logic [1:0] rt, input logic enc, input logic fmt,
		input logic tr, input logic ok, input logic [11:0] len);
		logic [255:0] seenB;
		runOp({7'h00, 1'b1, 4'h0, rt, fmt, enc, 4'h0, len}, tr, ok);
		if (ok) begin
			check(nWords, 64);
			check(nCmd, 0);
			check(lastAt, 63);
			check(srcSeen, (rt == 2'h0) ? 2'h2 : (rt == 2'h1) ? 2'h3 : 2'h1);
			check(rdst[63], (rt == 2'h0) ? 2'h2 : (rt == 2'h1) ? 2'h3 : 2'h1);
			check(encSeen, enc);
			check(fmtSeen, fmt);
			seenB = '0;
			for (int i = 0; i < 256; i++) seenB[res[i / 4][31 - 8 * (i % 4) -: 8]] = 1'b1;
			check(&seenB, 1'b1);
		end
	endtask : streamCase

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 6; a++) begin
			stall <= a[0];
			hashCase(4'(a), 2'h0, 2'h0, 1'b0, 1'b1, 12'h010);
		end
		stall <= 1'b0;
		for (int s = 0; s < 4; s++) begin
			for (int d = 0; d < 4; d++) begin
				hashCase(4'h0, 2'(s), 2'(d), 1'b0, routeLegal(2'(s), 2'(d)), 12'h010);
			end
		end
		hashCase(4'h0, 2'h1, 2'h1, 1'b1, 1'b1, 12'h010);
		hashCase(4'h0, 2'h0, 2'h0, 1'b1, 1'b0, 12'h010);
		hashCase(4'h0, 2'h0, 2'h0, 1'b0, 1'b1, 12'h040);
		hashCase(4'h0, 2'h0, 2'h0, 1'b0, 1'b0, 12'h041);
		hashCase(4'h6, 2'h0, 2'h0, 1'b0, 1'b0, 12'h010);
		hashCase(4'h0, 2'h0, 2'h0, 1'b0, 1'b1, 12'h005);
		spareWords <= 6'h08;
		hashCase(4'h0, 2'h0, 2'h0, 1'b0, 1'b0, 12'h010);
		spareWords <= 6'h09;
		hashCase(4'h0, 2'h0, 2'h0, 1'b0, 1'b1, 12'h010);
		spareWords <= 6'h3F;
		for (int r = 0; r < 4; r++) streamCase(2'(r), r[0], r[1], 1'b0, r != 3, 12'h010);
		streamCase(2'h2, 1'b1, 1'b1, 1'b1, 1'b1, 12'h100);
		streamCase(2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 12'h010);
		streamCase(2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 12'h000);
		streamCase(2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 12'h101);
		print_verdict;
	end
endmodule : derived_key_protocol_tb

// File: tb/key_link_assertions.sv
/* Concurrent checks on the link between the descriptor controller and the derived-key engine.
 * Assumes one clock domain and an instance beside the interface in the bench top. */
`timescale 1ns/1ps
module key_link_checker import dkp_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic cmdValid,
	input wire logic cmdReady,
	input wire word_t cmdWord,
	input wire logic inReady,
	input wire logic outValid,
	input wire logic outReady,
	input wire word_t outData,
	input wire route_t outDest,
	input wire logic outIsCmd,
	input wire logic outLast,
	input wire logic keyWrEn,
	input wire logic done,
	input wire logic err
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_cmd_held: assert property (cmdValid && !cmdReady |=> cmdValid && $stable(cmdWord))
		else $error("command changed before acceptance");
	// The controller only offers a command to an idle engine, so it is taken at once
	a_cmd_single: assert property (cmdValid |-> cmdReady ##1 !cmdValid)
		else $error("command offered to a busy engine or held too long");
	a_idle_quiet: assert property (cmdReady |-> !inReady && !outValid && !keyWrEn)
		else $error("idle engine is still moving data");
	// Refusal comes from the check state, two cycles after the take
	a_err_timing: assert property (err |-> $past(cmdValid && cmdReady, 2))
		else $error("error pulse not tied to a command");
	a_err_pulse: assert property (err |-> !done ##1 !err)
		else $error("error pulse too long or mixed with done");
	a_key_reg_first: assert property (keyWrEn |-> !outValid && !cmdReady)
		else $error("key register written outside the hash phase");
	a_keyload_word: assert property (outValid && outIsCmd |-> outDest == 2'h0 && outData[31:13] == 19'h02000
		&& outData[4:0] == 5'h00 && outData[12:5] inside {8'h20, 8'h30, 8'h40, 8'h80})
		else $error("rewritten command word malformed");
	a_out_held: assert property (outValid && !outReady |=> outValid && $stable(outData) && $stable(outDest)
		&& $stable(outLast))
		else $error("output word dropped while stalled");
	a_last_done: assert property (outValid && outReady && outLast |=> !outValid ##[0:1] done)
		else $error("no done after last word");
	a_done_idle: assert property (done |=> cmdReady && !done)
		else $error("engine not idle after done");
endmodule : key_link_checker
